/* include/fpe_defs.vh */
`ifndef FPE_DEFS_VH
`define FPE_DEFS_VH
// register byte offsets
`define FPE_A_CTRL   8'h00
`define FPE_A_KEY    8'h04
`define FPE_A_ADDR   8'h08
`define FPE_A_DATA0  8'h0C
`define FPE_A_DATA1  8'h10
`define FPE_A_PSTAT  8'h14
`define FPE_A_SSTAT  8'h18
`define FPE_A_ECCIRQ 8'h1C
`define FPE_A_INJADR 8'h20
`define FPE_A_INJPTR 8'h24
`define FPE_A_INJCTL 8'h28
`define FPE_A_SWAP   8'h2C
`define FPE_A_LOCK   8'h30
// control field positions
`define FPE_B_START  15
`define FPE_B_OPEN   14
`define FPE_B_SEQERR 13
`define FPE_B_SWDONE 11
`define FPE_B_P2ACT  10
// operation select codes
`define FPE_OP_DWORD 4'h1
`define FPE_OP_ROW   4'h2
`define FPE_OP_PAGE  4'h3
`define FPE_OP_IERA  4'h4
// unlock keys
`define FPE_KEY1     8'h55
`define FPE_KEY2     8'hAA
// write inhibit lock locations and activation values
`define FPE_LOCK1_A  24'h80_1034
`define FPE_LOCK2_A  24'h80_1038
`define FPE_LOCK1_V  16'h6D63
`define FPE_LOCK2_V  16'h6870
// inactive partition address bit and no-fault pointer
`define FPE_PART_BIT 22
`define FPE_PTR_NONE 8'hFF
`define FPE_RESP_OK  2'b00
`define FPE_RESP_ERR 2'b10
`endif

/* rtl/fpe_ctrl.v */
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defs.vh"
module fpe_ctrl (
    input  wire        ref_clk,
    input  wire        reset_n,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        fetch_valid,
    input  wire [23:0] fetch_addr,
    input  wire [47:0] fetch_data,
    input  wire [6:0]  fetch_parity,
    input  wire        arr_done,
    input  wire [15:0] lock1_word,
    input  wire [15:0] lock2_word,
    input  wire [23:0] boot_seq_word1,
    input  wire [23:0] boot_seq_word2,
    input  wire        prot_dual_mode,
    input  wire        ext_prog_mode,
    input  wire        ext_cmd_valid,
    input  wire        ext_cmd_check,
    input  wire        ext_cmd_match,
    input  wire        dbg_write_req,
    input  wire        prod_switch_req,
    output reg         arr_start,
    output reg  [3:0]  arr_op,
    output reg  [23:0] arr_addr,
    output reg         arr_partition,
    output reg  [47:0] arr_wdata,
    output reg  [6:0]  arr_wparity,
    output reg         cpu_stall,
    output reg         rd_valid,
    output reg  [47:0] rd_data,
    output reg         single_error_irq,
    output reg         double_error_trap,
    output reg         ext_resp_valid,
    output reg         ext_resp_pass,
    output reg         ext_cmd_allow,
    output reg         dbg_write_allow,
    output reg         prod_switch_allow,
    output reg         write_inhibit,
    output reg         jump_valid,
    output reg  [23:0] jump_target,
    output reg         jump_partition
);
    localparam K_IDLE  = 2'd0;
    localparam K_ONE   = 2'd1;
    localparam K_ARMED = 2'd2;

    // hamming check bits over data placed at positions 3.., skipping powers of two
    function [6:0] fpe_ecc;
        input [47:0] d;
        integer i;
        integer p;
        reg [5:0] s;
        begin
            s = 6'h00;
            p = 3;
            for (i = 0; i < 48; i = i + 1) begin
                if (p == 4 || p == 8 || p == 16 || p == 32)
                    p = p + 1;
                if (d[i])
                    s = s ^ p[5:0];
                p = p + 1;
            end
            fpe_ecc = {(^d) ^ (^s), s};
        end
    endfunction

    // invert the data bit whose code position equals the syndrome
    function [47:0] fpe_fix;
        input [47:0] d;
        input [5:0]  syn;
        integer i;
        integer p;
        begin
            fpe_fix = d;
            p = 3;
            for (i = 0; i < 48; i = i + 1) begin
                if (p == 4 || p == 8 || p == 16 || p == 32)
                    p = p + 1;
                if (p[5:0] == syn)
                    fpe_fix[i] = ~d[i];
                p = p + 1;
            end
        end
    endfunction

    // fault mask from two bit pointers; all ones means no bit
    function [47:0] fpe_mask;
        input [7:0] p1;
        input [7:0] p2;
        integer i;
        begin
            fpe_mask = 48'h0000_0000_0000;
            for (i = 0; i < 48; i = i + 1)
                if (i == p1 || (p2 != `FPE_PTR_NONE && i == p2))
                    fpe_mask[i] = 1'b1;
        end
    endfunction

    reg [1:0]  key_state;
    reg        busy;
    reg        op_enable;
    reg        seq_err;
    reg        swap_done;
    reg        p2_active;
    reg [3:0]  op_sel;
    reg [23:0] flash_addr;
    reg [23:0] wdata0;
    reg [23:0] wdata1;
    reg [7:0]  exp_cpar;
    reg [7:0]  rd_cpar;
    reg [7:0]  err_syn;
    reg        exp_dpar;
    reg        rd_dpar;
    reg        sbe_flag;
    reg        sbe_en;
    reg        dbe_flag;
    reg [23:0] inj_addr;
    reg [7:0]  ptr1;
    reg [7:0]  ptr2;
    reg        inj_en;
    reg        init_done;
    reg [7:0]  aw_q;
    reg [31:0] wd_q;
    reg        strb_full;
    reg [31:0] rd_mux;
    reg        rd_hit;

    // write commit once both address and data are held
    wire        commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire        wr_ok  = commit && strb_full;
    wire        wr_ctl = wr_ok && aw_q == `FPE_A_CTRL;
    wire        wr_key = wr_ok && aw_q == `FPE_A_KEY;
    wire        wr_swp = wr_ok && aw_q == `FPE_A_SWAP;
    wire        wr_inj = wr_ok && aw_q == `FPE_A_INJCTL;
    wire        armed  = key_state == K_ARMED;
    wire [3:0]  nop    = wd_q[3:0];
    wire        try_go = wr_ctl && wd_q[`FPE_B_START];

    // lock locations accept only a fresh double-word with the right value
    wire lk1 = flash_addr == `FPE_LOCK1_A;
    wire lk2 = flash_addr == `FPE_LOCK2_A;
    wire lock_bad = (lk1 || lk2) && (nop != `FPE_OP_DWORD ||
        (lk1 && (wdata0[15:0] != `FPE_LOCK1_V || lock1_word == `FPE_LOCK1_V)) ||
        (lk2 && (wdata0[15:0] != `FPE_LOCK2_V || lock2_word == `FPE_LOCK2_V)));
    // operation target lies in the inactive partition
    wire to_inact = nop == `FPE_OP_IERA || flash_addr[`FPE_PART_BIT];
    wire tgt_p1   = to_inact ? p2_active : !p2_active;
    wire prot_bad = prot_dual_mode && !flash_addr[23] && tgt_p1;
    wire inh_bad  = write_inhibit && ext_prog_mode;
    wire op_valid = nop == `FPE_OP_DWORD || nop == `FPE_OP_ROW ||
                    nop == `FPE_OP_PAGE || nop == `FPE_OP_IERA;
    wire go_ok = try_go && armed && wd_q[`FPE_B_OPEN] && op_valid &&
                 !busy && !inh_bad && !lock_bad && !prot_bad;
    wire go_bad = try_go && !go_ok;

    // fetch check with optional read-path fault injection
    wire        inj_hit = inj_en && fetch_addr[23:2] == inj_addr[23:2];
    wire [47:0] f_data  = inj_hit ? fetch_data ^ fpe_mask(ptr1, ptr2)
                                  : fetch_data;
    wire [6:0]  f_exp   = fpe_ecc(f_data);
    wire [5:0]  f_syn   = f_exp[5:0] ^ fetch_parity[5:0];
    wire        f_odd   = (^f_data) ^ (^fetch_parity);
    wire        f_sbe   = fetch_valid && f_odd;
    wire        f_dbe   = fetch_valid && !f_odd && f_syn != 6'h00;
    wire [47:0] w_data  = {wdata1, wdata0};
    wire        w_inj   = inj_en && flash_addr[23:2] == inj_addr[23:2];

    // boot sequence numbers valid when the upper half complements the lower
    wire b1_ok = boot_seq_word1[23:12] == ~boot_seq_word1[11:0];
    wire b2_ok = boot_seq_word2[23:12] == ~boot_seq_word2[11:0];
    wire pick2 = b2_ok && (!b1_ok ||
                 boot_seq_word2[11:0] < boot_seq_word1[11:0]);

    // register read mux
    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            `FPE_A_CTRL: begin
                rd_mux[`FPE_B_START]  = busy;
                rd_mux[`FPE_B_OPEN]   = op_enable;
                rd_mux[`FPE_B_SEQERR] = seq_err;
                rd_mux[`FPE_B_SWDONE] = swap_done;
                rd_mux[`FPE_B_P2ACT]  = p2_active;
                rd_mux[3:0]           = op_sel;
            end
            `FPE_A_KEY:    rd_mux = 32'h0000_0000;
            `FPE_A_ADDR:   rd_mux[23:0] = flash_addr;
            `FPE_A_DATA0:  rd_mux[23:0] = wdata0;
            `FPE_A_DATA1:  rd_mux[23:0] = wdata1;
            `FPE_A_PSTAT:  rd_mux[15:0] = {rd_cpar, exp_cpar};
            `FPE_A_SSTAT:  rd_mux[9:0]  = {rd_dpar, exp_dpar, err_syn};
            `FPE_A_ECCIRQ: rd_mux[2:0]  = {dbe_flag, sbe_en, sbe_flag};
            `FPE_A_INJADR: rd_mux[23:0] = inj_addr;
            `FPE_A_INJPTR: rd_mux[15:0] = {ptr2, ptr1};
            `FPE_A_INJCTL: rd_mux[0]    = inj_en;
            `FPE_A_SWAP:   rd_mux = 32'h0000_0000;
            `FPE_A_LOCK:   rd_mux[1:0]  = {prot_dual_mode, write_inhibit};
            default:       rd_hit = 1'b0;
        endcase
    end

    // bus slave: address and data taken in either order, then one response
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `FPE_RESP_OK;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `FPE_RESP_OK;
            aw_q          <= 8'h00;
            wd_q          <= 32'h0000_0000;
            strb_full     <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_q          <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wd_q         <= s_axi_wdata;
                strb_full    <= s_axi_wstrb == 4'hF;
            end
            if (commit) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (strb_full && aw_q <= `FPE_A_LOCK &&
                                 aw_q[1:0] == 2'b00) ? `FPE_RESP_OK
                                                     : `FPE_RESP_ERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_hit ? `FPE_RESP_OK : `FPE_RESP_ERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // unlock sequence, operation sequencer and control register
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            key_state   <= K_IDLE;
            busy        <= 1'b0;
            op_enable   <= 1'b0;
            seq_err     <= 1'b0;
            op_sel      <= 4'h0;
            flash_addr  <= 24'h00_0000;
            wdata0      <= 24'h00_0000;
            wdata1      <= 24'h00_0000;
            arr_start   <= 1'b0;
            arr_op      <= 4'h0;
            arr_addr    <= 24'h00_0000;
            arr_partition <= 1'b0;
            arr_wdata   <= 48'h0000_0000_0000;
            arr_wparity <= 7'h00;
            cpu_stall   <= 1'b0;
        end else begin
            arr_start <= 1'b0;
            if (wr_key) begin
                if (wd_q[7:0] == `FPE_KEY1)
                    key_state <= K_ONE;
                else if (wd_q[7:0] == `FPE_KEY2 && key_state == K_ONE)
                    key_state <= K_ARMED;
                else
                    key_state <= K_IDLE;
            end else if (try_go || wr_swp || (wr_inj && wd_q[0])) begin
                key_state <= K_IDLE;
            end
            if (wr_ok && aw_q == `FPE_A_ADDR)
                flash_addr <= wd_q[23:0];
            if (wr_ok && aw_q == `FPE_A_DATA0)
                wdata0 <= wd_q[23:0];
            if (wr_ok && aw_q == `FPE_A_DATA1)
                wdata1 <= wd_q[23:0];
            if (wr_ctl && !busy) begin
                op_enable <= wd_q[`FPE_B_OPEN];
                op_sel    <= nop;
            end
            // a refused start sets the error; that set beats a clear
            if (go_bad)
                seq_err <= 1'b1;
            else if (wr_ctl)
                seq_err <= wd_q[`FPE_B_SEQERR];
            if (go_ok) begin
                busy        <= 1'b1;
                arr_start   <= 1'b1;
                arr_op      <= nop;
                arr_addr    <= (nop == `FPE_OP_DWORD) ?
                               {flash_addr[23:2], 2'b10} : flash_addr;
                arr_partition <= tgt_p1 ? 1'b0 : 1'b1;
                arr_wdata   <= w_inj ? w_data ^ fpe_mask(ptr1, ptr2)
                                     : w_data;
                arr_wparity <= fpe_ecc(w_data);
                cpu_stall   <= !to_inact;
            end else if (busy && arr_done) begin
                busy      <= 1'b0;
                cpu_stall <= 1'b0;
            end
        end
    end

    // ecc status, flags and fault injection control
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            exp_cpar <= 8'h00;
            rd_cpar  <= 8'h00;
            err_syn  <= 8'h00;
            exp_dpar <= 1'b0;
            rd_dpar  <= 1'b0;
            sbe_flag <= 1'b0;
            sbe_en   <= 1'b0;
            dbe_flag <= 1'b0;
            inj_addr <= 24'h00_0000;
            ptr1     <= `FPE_PTR_NONE;
            ptr2     <= `FPE_PTR_NONE;
            inj_en   <= 1'b0;
            rd_valid <= 1'b0;
            rd_data  <= 48'h0000_0000_0000;
            single_error_irq  <= 1'b0;
            double_error_trap <= 1'b0;
        end else begin
            rd_valid <= fetch_valid;
            if (fetch_valid)
                rd_data <= f_sbe ? fpe_fix(f_data, f_syn) : f_data;
            if (f_sbe) begin
                exp_cpar <= {1'b0, f_exp};
                rd_cpar  <= {1'b0, fetch_parity};
                err_syn  <= {2'b00, f_syn};
            end
            if (f_dbe) begin
                exp_dpar <= f_exp[6];
                rd_dpar  <= fetch_parity[6];
            end
            // hardware sets win over a same-cycle write-one clear
            if (f_sbe)
                sbe_flag <= 1'b1;
            else if (wr_ok && aw_q == `FPE_A_ECCIRQ && wd_q[0])
                sbe_flag <= 1'b0;
            if (f_dbe)
                dbe_flag <= 1'b1;
            else if (wr_ok && aw_q == `FPE_A_ECCIRQ && wd_q[2])
                dbe_flag <= 1'b0;
            if (wr_ok && aw_q == `FPE_A_ECCIRQ)
                sbe_en <= wd_q[1];
            single_error_irq  <= (sbe_flag || f_sbe) && sbe_en;
            double_error_trap <= f_dbe;
            if (wr_ok && aw_q == `FPE_A_INJADR)
                inj_addr <= wd_q[23:0];
            if (wr_ok && aw_q == `FPE_A_INJPTR) begin
                ptr1 <= wd_q[7:0];
                ptr2 <= wd_q[15:8];
            end
            if (wr_inj)
                inj_en <= wd_q[0] && armed;
        end
    end

    // reset-time selection, soft swap, external and debug gating
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            init_done      <= 1'b0;
            write_inhibit  <= 1'b0;
            p2_active      <= 1'b0;
            swap_done      <= 1'b0;
            jump_valid     <= 1'b0;
            jump_target    <= 24'h00_0000;
            jump_partition <= 1'b0;
            ext_resp_valid <= 1'b0;
            ext_resp_pass  <= 1'b0;
            ext_cmd_allow  <= 1'b0;
            dbg_write_allow   <= 1'b0;
            prod_switch_allow <= 1'b0;
        end else begin
            jump_valid <= 1'b0;
            if (!init_done) begin
                init_done     <= 1'b1;
                write_inhibit <= lock1_word == `FPE_LOCK1_V &&
                                 lock2_word == `FPE_LOCK2_V;
                p2_active     <= pick2;
            end else if (wr_swp) begin
                jump_valid  <= 1'b1;
                jump_target <= wd_q[23:0];
                if (armed) begin
                    p2_active      <= !p2_active;
                    jump_partition <= !p2_active;
                end else begin
                    jump_partition <= p2_active;
                end
            end
            if (init_done && wr_swp && armed)
                swap_done <= 1'b1;
            else if (wr_ctl && !wd_q[`FPE_B_SWDONE])
                swap_done <= 1'b0;
            ext_resp_valid <= ext_cmd_valid;
            ext_cmd_allow  <= ext_cmd_valid && !write_inhibit;
            ext_resp_pass  <= ext_cmd_valid && (!write_inhibit ||
                              (ext_cmd_check && ext_cmd_match));
            dbg_write_allow   <= dbg_write_req && !write_inhibit;
            prod_switch_allow <= prod_switch_req && !write_inhibit;
        end
    end
endmodule
`default_nettype wire

/* dv/fpe_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module fpe_ctrl_properties (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        fetch_valid,
    input wire logic        arr_done,
    input wire logic        ext_cmd_valid,
    input wire logic        ext_cmd_check,
    input wire logic        ext_cmd_match,
    input wire logic        ext_prog_mode,
    input wire logic        dbg_write_req,
    input wire logic        arr_start,
    input wire logic [3:0]  arr_op,
    input wire logic [23:0] arr_addr,
    input wire logic        cpu_stall,
    input wire logic        rd_valid,
    input wire logic        double_error_trap,
    input wire logic        ext_resp_valid,
    input wire logic        ext_resp_pass,
    input wire logic        dbg_write_allow,
    input wire logic        write_inhibit
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    stall_start_a: assert property (
        arr_start && !arr_addr[22] && arr_op != 4'h4 |-> cpu_stall)
        else $error("no stall");
    inactive_run_a: assert property (
        arr_start && arr_addr[22] |-> !cpu_stall)
        else $error("stall on inactive");
    stall_release_a: assert property (
        cpu_stall && arr_done |=> !cpu_stall) else $error("stall held");
    read_follow_a: assert property (
        rd_valid |-> $past(fetch_valid)) else $error("stray read");
    trap_pulse_a: assert property (
        double_error_trap |=> !double_error_trap) else $error("trap held");
    ext_answer_a: assert property (
        ext_cmd_valid |=> ext_resp_valid && ext_resp_pass ==
        (!$past(write_inhibit) || $past(ext_cmd_check && ext_cmd_match)))
        else $error("bad ext answer");
    inhibit_start_a: assert property (
        write_inhibit && ext_prog_mode |-> !arr_start)
        else $error("start inhibited");
    debug_block_a: assert property (
        dbg_write_req |=> dbg_write_allow == !$past(write_inhibit))
        else $error("debug");
endmodule
bind fpe_ctrl fpe_ctrl_properties u_props (.*);
`default_nettype wire

/* dv/fpe_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fpe_array_model (
    input  wire logic        ref_clk,
    input  wire logic        slow,
    input  wire logic        arr_start,
    input  wire logic [47:0] arr_wdata,
    input  wire logic [6:0]  arr_wparity,
    output var  logic        arr_done,
    output var  logic [47:0] cell_data,
    output var  logic [6:0]  cell_parity
);
    int cnt = 0;
    initial arr_done = 0;
    // stores the pair and ends each operation after a short or long time
    always @(posedge ref_clk) begin
        arr_done <= cnt == 1;
        cnt <= arr_start ? (slow ? 20 : 2) : (cnt > 0 ? cnt - 1 : 0);
        if (arr_start) begin
            cell_data <= arr_wdata;
            cell_parity <= arr_wparity;
        end
    end
endmodule
`default_nettype wire

/* dv/flash_program_erase_ecc_controller_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defs.vh"
module flash_program_erase_ecc_controller_tb_top;
    localparam logic [47:0] WD = 48'h1234_5612_3456;
    logic        ref_clk = 0, reset_n = 0, slow = 0, last_jp = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic        s_axi_bready = 1, s_axi_rready = 1, fetch_valid = 0;
    logic        ext_prog_mode = 0, ext_cmd_valid = 0, ext_cmd_check = 0;
    logic        ext_cmd_match = 0, prot_dual_mode = 0, dbg_write_req = 0;
    logic        prod_switch_req = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, arr_start;
    logic        arr_partition, arr_done;
    logic        cpu_stall, rd_valid, single_error_irq, double_error_trap;
    logic        ext_resp_valid, ext_resp_pass, ext_cmd_allow, dbg_write_allow;
    logic        prod_switch_allow, write_inhibit, jump_valid, jump_partition;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb = 4'hF, arr_op;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [47:0] fetch_data = 0, cell_data, arr_wdata, rd_data;
    logic [6:0]  fetch_parity = 0, cell_parity, arr_wparity;
    logic [15:0] lock1_word = 0, lock2_word = 0;
    logic [23:0] fetch_addr = 24'h00_0002, arr_addr, jump_target;
    logic [23:0] boot_seq_word1 = 24'hFF_E001, boot_seq_word2 = 24'hFF_D002;
    int          num_errors = 0, n_checks = 0, n_start = 0, i;
    fpe_ctrl u_dut (.*);
    fpe_array_model u_array (.*);
    always #4 ref_clk = ~ref_clk;
    // counts launches and keeps the partition of the last jump
    always @(posedge ref_clk) begin
        if (arr_start) n_start++;
        if (jump_valid) last_jp <= jump_partition;
    end
    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [47:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tmo();
        if (i >= 64) begin
            num_errors++;
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        for (i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        tmo();
    endtask
    task automatic rck(string nm, logic [7:0] a, logic [31:0] m, e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        for (i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        rv = s_axi_rdata;
        tmo();
        chk(nm, rv & m, e);
    endtask
    task automatic go(input logic [31:0] c);
        wr(`FPE_A_KEY, 32'h0000_0055);
        wr(`FPE_A_KEY, 32'h0000_00AA);
        if (c != 0) wr(`FPE_A_CTRL, c);
        #1;
    endtask
    task automatic done();
        for (i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            if (arr_done) break;
        end
        @(posedge ref_clk);
        tmo();
    endtask
    task automatic fetch(input logic [47:0] m);
        fetch_data <= cell_data ^ m;
        fetch_parity <= cell_parity;
        fetch_valid <= 1;
        @(posedge ref_clk);
        fetch_valid <= 0;
        #1;
    endtask
    task automatic rst();
        reset_n <= 0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1;
        repeat (2) @(posedge ref_clk);
    endtask
    initial begin
        rst();
        rck("ctrl", `FPE_A_CTRL, 32'hFFFF_FFFF, 0);
        rck("ptrs", `FPE_A_INJPTR, 32'hFFFF_FFFF, 32'h0000_FFFF);
        // refused: no key, reserved code, enable clear, cancelled key
        for (int k = 0; k < 4; k++) begin
            if (k > 0) go(0);
            if (k == 3) wr(`FPE_A_KEY, 0);
            wr(`FPE_A_CTRL, k == 1 ? 32'hC005 : k == 2 ? 32'h8001 : 32'hC001);
            rck("refused", `FPE_A_CTRL, 32'hA000, 32'h2000);
            wr(`FPE_A_CTRL, 0);
        end
        chk("starts", n_start, 0);
        $display("refusal test done");
        wr(`FPE_A_ADDR, 32'h0000_0002);
        wr(`FPE_A_DATA0, WD[23:0]);
        wr(`FPE_A_DATA1, WD[47:24]);
        go(32'h0000_C001);
        chk("stall", cpu_stall, 1);
        chk("op", {arr_op, arr_addr}, {4'h1, 24'h00_0002});
        done();
        rck("busy", `FPE_A_CTRL, 32'h8000, 0);
        chk("stored", cell_data, WD);
        fetch(0);
        chk("clean", rd_data, WD);
        fetch(48'h20);
        chk("fixed", rd_data, WD);
        rck("synd", `FPE_A_SSTAT, 32'hFF, 32'h0A);
        wr(`FPE_A_ECCIRQ, 32'h2);
        #1 chk("irq", single_error_irq, 1);
        wr(`FPE_A_ECCIRQ, 32'h3);
        @(posedge ref_clk);
        #1 chk("irq_clr", single_error_irq, 0);
        fetch(48'h60);
        chk("double", rd_data, WD ^ 48'h60);
        rck("trap", `FPE_A_ECCIRQ, 32'h4, 32'h4);
        // read path injection of data bit 0
        wr(`FPE_A_INJADR, 32'h0000_0002);
        wr(`FPE_A_INJPTR, 32'hFF00);
        go(0);
        wr(`FPE_A_INJCTL, 1);
        fetch(0);
        chk("inj", rd_data, WD);
        rck("inj_synd", `FPE_A_SSTAT, 32'hFF, 32'h03);
        wr(`FPE_A_INJCTL, 0);
        $display("program and ecc test done");
        slow <= 1;
        wr(`FPE_A_ADDR, 32'h0040_0002);
        go(32'h0000_C003);
        chk("no_stall", cpu_stall, 0);
        done();
        wr(`FPE_A_SWAP, 32'h100);
        rck("noswap", `FPE_A_CTRL, 32'hC00, 0);
        chk("nojump", last_jp, 0);
        go(0);
        wr(`FPE_A_SWAP, 32'h100);
        rck("swapped", `FPE_A_CTRL, 32'hC00, 32'hC00);
        chk("jump", last_jp, 1);
        // partition 1 is now inactive; protected mode must refuse it
        prot_dual_mode <= 1;
        wr(`FPE_A_ADDR, 32'h0040_0002);
        go(32'h0000_C003);
        rck("prot", `FPE_A_CTRL, 32'hA000, 32'h2000);
        prot_dual_mode <= 0;
        wr(`FPE_A_CTRL, 0);
        rck("swclr", `FPE_A_CTRL, 32'h800, 0);
        $display("partition test done");
        // second pass with both locks written and partition 2 preferred
        for (int k = 0; k < 2; k++) begin
            if (k) begin
                lock1_word <= 16'h6D63;
                lock2_word <= 16'h6870;
                boot_seq_word1 <= 24'hFF_C003;
                ext_prog_mode <= 1;
                rst();
                rck("lock", `FPE_A_LOCK, 1, 1);
                rck("boot", `FPE_A_CTRL, 32'h400, 32'h400);
                go(32'h0000_C001);
                rck("inhib", `FPE_A_CTRL, 32'hA000, 32'h2000);
            end
            for (int j = 0; j < 4; j++) begin
                ext_cmd_check <= j[0];
                ext_cmd_match <= j[1];
                ext_cmd_valid <= 1;
                dbg_write_req <= 1;
                prod_switch_req <= 1;
                @(posedge ref_clk);
                ext_cmd_valid <= 0;
                #1 chk("ext", ext_resp_pass, !k || j == 3);
                chk("dbg", {dbg_write_allow, prod_switch_allow}, {2{!k}});
            end
        end
        $display("inhibit test done");
        results();
    end
endmodule
`default_nettype wire
